/* File: design/acl_consts.svh */
// Offsets, field positions, reset values and timing counts of the ACL action stage
`ifndef ACL_CONSTS_SVH
`define ACL_CONSTS_SVH

// Table geometry
`define ACL_NUM_ENTRIES 16
`define ACL_IDX_W 4
`define ACL_MAP_W 7
`define ACL_CNT_W 11

// Register byte offsets on the Avalon-MM slave
`define ACL_ADDR_W 6
`define ACL_OFF_CTRL 6'h00
`define ACL_OFF_INDEX 6'h04
`define ACL_OFF_MATCH 6'h08
`define ACL_OFF_ACTION 6'h0c
`define ACL_OFF_PROCESS 6'h10
`define ACL_OFF_PORT_STAT 6'h14
`define ACL_OFF_PORT_MASK 6'h18
`define ACL_OFF_GLB_STAT 6'h1c
`define ACL_OFF_GLB_MASK 6'h20

// Matching field layout
`define ACL_M_MODE_LO 0
`define ACL_M_SUB_LO 2
`define ACL_MODE_OFF 2'h0
`define ACL_MODE_L2_CNT 2'h1
`define ACL_SUB_COUNT 2'h0

// Action field layout; count value occupies bits 10:0 across the action fields
`define ACL_A_PM_LO 0
`define ACL_A_PRIO_LO 2
`define ACL_A_RPE 5
`define ACL_A_RP_LO 6
`define ACL_A_MM_LO 9
`define ACL_A_TBS 11
`define ACL_A_ALG 12
`define ACL_A_FWD_LO 16

// Reset values
`define ACL_RST_WORD 32'h0000_0000
`define ACL_RST_MASK 1'b0

// Time base
`define ACL_CLK_PERIOD_NS 20
`define ACL_US_NS 1000
`define ACL_US_CYCLES (`ACL_US_NS / `ACL_CLK_PERIOD_NS)
`define ACL_US_PER_MS 1000

`endif

/* File: design/acl_pkg.sv */
// Types shared by the ACL action stage and its count engine
`include "acl_consts.svh"
package acl_pkg;

  typedef enum logic [1:0] {
    ACL_PM_QOS = 2'h0,
    ACL_PM_GT = 2'h1,
    ACL_PM_LT = 2'h2,
    ACL_PM_ALWAYS = 2'h3
  } acl_prio_mode_t;

  typedef enum logic [1:0] {
    ACL_MM_KEEP = 2'h0,
    ACL_MM_OR = 2'h1,
    ACL_MM_AND = 2'h2,
    ACL_MM_REPLACE = 2'h3
  } acl_map_mode_t;

  typedef enum logic [1:0] {
    ACL_ENG_IDLE = 2'b01,
    ACL_ENG_RUN = 2'b10
  } acl_eng_state_t;

  // Decoded action field
  typedef struct packed {
    acl_prio_mode_t priority_mode;
    logic [2:0] priority_value;
    logic remark_enable;
    logic [2:0] remark_priority;
    acl_map_mode_t map_mode;
    logic time_base_select;
    logic counter_algorithm;
    logic [`ACL_MAP_W-1:0] fwd_map;
  } acl_action_t;

  // Frame presented by the lookup and QoS pipeline
  typedef struct packed {
    logic valid;
    logic [`ACL_NUM_ENTRIES-1:0] rule_hit;
    logic [`ACL_NUM_ENTRIES-1:0] mac_hit;
    logic [`ACL_NUM_ENTRIES-1:0] type_hit;
    logic [2:0] qos_prio;
    logic [2:0] pcp;
    logic [`ACL_MAP_W-1:0] lut_map;
  } acl_frame_t;

  // Result handed back to the pipeline
  typedef struct packed {
    logic valid;
    logic [2:0] prio;
    logic [2:0] pcp;
    logic remarked;
    logic [`ACL_MAP_W-1:0] fwd_map;
  } acl_result_t;

endpackage

/* File: design/acl_cnt_engine.sv */
// Count-mode engine for one table entry: interval timer or frame counter
`timescale 1ns/1ps
`include "acl_consts.svh"
module acl_cnt_engine (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_enable,
  input wire logic i_alg,
  input wire logic i_tb_sel,
  input wire logic [`ACL_CNT_W-1:0] i_count,
  input wire logic i_us_tick,
  input wire logic i_ms_tick,
  input wire logic i_pkt,
  output logic o_expire
);

  acl_pkg::acl_eng_state_t state_r;
  logic [`ACL_CNT_W-1:0] cnt_r;
  logic tick;

  // Time unit select, unused by the frame counter
  assign tick = i_tb_sel ? i_ms_tick : i_us_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r <= acl_pkg::ACL_ENG_IDLE;
      cnt_r <= '0;
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (!i_enable) begin
        state_r <= acl_pkg::ACL_ENG_IDLE;
        cnt_r <= '0;
      end else if (i_alg) begin
        // Frame counter; time base ignored
        state_r <= acl_pkg::ACL_ENG_RUN;
        if (i_pkt) begin
          if (cnt_r + 11'h001 >= i_count) begin
            o_expire <= 1'b1;
            cnt_r <= '0;
          end else begin
            cnt_r <= cnt_r + 11'h001;
          end
        end
      end else begin
        case (state_r)
          acl_pkg::ACL_ENG_IDLE: begin
            if (i_pkt) begin
              cnt_r <= i_count;
              state_r <= acl_pkg::ACL_ENG_RUN;
            end
          end
          acl_pkg::ACL_ENG_RUN: begin
            if (i_pkt) begin
              cnt_r <= i_count;
            end else if (tick) begin
              if (cnt_r <= 11'h001) begin
                o_expire <= 1'b1;
                cnt_r <= '0;
                state_r <= acl_pkg::ACL_ENG_IDLE;
              end else begin
                cnt_r <= cnt_r - 11'h001;
              end
            end
          end
          default: begin
            state_r <= acl_pkg::ACL_ENG_IDLE;
          end
        endcase
      end
    end
  end

endmodule // acl_cnt_engine

/* File: design/acl_action_count_logic.sv */
// ACL action stage with count-mode interrupt engine and Avalon-MM registers
//
// Functional notes
// - Mode 00 keeps QoS priority; 11 always overrides
// - Mode 01 overrides if greater; 10 if smaller
// - Remark enable replaces tag PCP with remark value
// - Map 00 keeps lookup map; 01 ORs
// - Map 10 ANDs maps; 11 replaces with rule map
// - Rule map bit n means port n+1
// - Time base select: 0 microseconds, 1 milliseconds
// - Algorithm 0 loads count, decrements per unit
// - Algorithm 0 interrupts when timer expires unrefreshed
// - Algorithm 1 counts matched frames, ignores time base
// - Algorithm 1 interrupts at terminal count, restarts
// - Table holds 16 entries: match, action, process
// - Fields independent except in count mode
// - Only count-mode entries cause interrupts
// - Port interrupt has own status and mask
// - Global per-port status and mask gate it
// - Enable bit turns rule processing on/off
// - Count value is the concatenated action fields
// - Counting needs both MAC and EtherType match
//
// Local design decisions: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "acl_consts.svh"
module acl_action_count_logic #(
  parameter int US_CYCLES = `ACL_US_CYCLES,
  parameter int US_PER_MS = `ACL_US_PER_MS
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [`ACL_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire acl_pkg::acl_frame_t i_frm,
  output acl_pkg::acl_result_t o_res,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Entry is in count mode when rule mode is 01 and submode 00
  function automatic logic is_count(input logic [3:0] m);
    return (m[`ACL_M_MODE_LO +: 2] == `ACL_MODE_L2_CNT) &&
           (m[`ACL_M_SUB_LO +: 2] == `ACL_SUB_COUNT);
  endfunction

  // Unpack a stored action word
  function automatic acl_pkg::acl_action_t decode_action(input logic [31:0] w);
    acl_pkg::acl_action_t a;
    a.priority_mode = acl_pkg::acl_prio_mode_t'(w[`ACL_A_PM_LO +: 2]);
    a.priority_value = w[`ACL_A_PRIO_LO +: 3];
    a.remark_enable = w[`ACL_A_RPE];
    a.remark_priority = w[`ACL_A_RP_LO +: 3];
    a.map_mode = acl_pkg::acl_map_mode_t'(w[`ACL_A_MM_LO +: 2]);
    a.time_base_select = w[`ACL_A_TBS];
    a.counter_algorithm = w[`ACL_A_ALG];
    a.fwd_map = w[`ACL_A_FWD_LO +: `ACL_MAP_W];
    return a;
  endfunction

  // Priority decision against the QoS result
  function automatic logic [2:0] apply_prio(input acl_pkg::acl_prio_mode_t pm,
                                            input logic [2:0] rule_p,
                                            input logic [2:0] qos_p);
    logic [2:0] res;
    res = qos_p;
    case (pm)
      acl_pkg::ACL_PM_QOS: res = qos_p;
      acl_pkg::ACL_PM_GT: res = (rule_p > qos_p) ? rule_p : qos_p;
      acl_pkg::ACL_PM_LT: res = (rule_p < qos_p) ? rule_p : qos_p;
      acl_pkg::ACL_PM_ALWAYS: res = rule_p;
      default: res = qos_p;
    endcase
    return res;
  endfunction

  // Forwarding map combination; bit n of either map is port n+1
  function automatic logic [`ACL_MAP_W-1:0] apply_map(input acl_pkg::acl_map_mode_t mm,
                                                      input logic [`ACL_MAP_W-1:0] rule_m,
                                                      input logic [`ACL_MAP_W-1:0] lut_m);
    logic [`ACL_MAP_W-1:0] res;
    res = lut_m;
    case (mm)
      acl_pkg::ACL_MM_KEEP: res = lut_m;
      acl_pkg::ACL_MM_OR: res = rule_m | lut_m;
      acl_pkg::ACL_MM_AND: res = rule_m & lut_m;
      acl_pkg::ACL_MM_REPLACE: res = rule_m;
      default: res = lut_m;
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic acl_en_r;
  logic [`ACL_IDX_W-1:0] idx_r;
  logic [3:0] match_mem [`ACL_NUM_ENTRIES];
  logic [31:0] act_mem [`ACL_NUM_ENTRIES];
  logic [`ACL_IDX_W-1:0] proc_mem [`ACL_NUM_ENTRIES];
  logic port_stat_r;
  logic port_mask_r;
  logic glb_mask_r;
  logic wait_r;
  logic [`ACL_NUM_ENTRIES-1:0] expire;
  logic us_tick_r;
  logic ms_tick_r;
  logic [15:0] us_cnt_r;
  logic [15:0] ms_cnt_r;
  logic wr_go;
  logic rd_go;
  logic any_expire;

  assign wr_go = i_avs_write & ~wait_r;
  // Read data is loaded when the read is first seen, so it stands in the answer cycle
  assign rd_go = i_avs_read & wait_r;
  assign any_expire = |expire;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the request is taken
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wait_r <= 1'b1;
    end else if ((i_avs_read | i_avs_write) & wait_r) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= 1'b1;
    end
  end

  assign o_avs_waitrequest = wait_r;

  // Control, index and mask registers
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      acl_en_r <= 1'b0;
      idx_r <= '0;
      port_mask_r <= `ACL_RST_MASK;
      glb_mask_r <= `ACL_RST_MASK;
    end else if (wr_go && i_avs_byteenable[0]) begin
      case (i_avs_address)
        `ACL_OFF_CTRL: acl_en_r <= i_avs_writedata[0];
        `ACL_OFF_INDEX: idx_r <= i_avs_writedata[`ACL_IDX_W-1:0];
        `ACL_OFF_PORT_MASK: port_mask_r <= i_avs_writedata[0];
        `ACL_OFF_GLB_MASK: glb_mask_r <= i_avs_writedata[0];
        default: ;
      endcase
    end
  end

  // Rule table: 16 entries of match, action and process fields
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int e = 0; e < `ACL_NUM_ENTRIES; e++) begin
        match_mem[e] <= '0;
        act_mem[e] <= `ACL_RST_WORD;
        proc_mem[e] <= '0;
      end
    end else if (wr_go) begin
      case (i_avs_address)
        `ACL_OFF_MATCH: begin
          match_mem[idx_r] <= 4'(be_merge({28'h0, match_mem[idx_r]}, i_avs_writedata,
                                          i_avs_byteenable));
        end
        `ACL_OFF_ACTION: begin
          act_mem[idx_r] <= be_merge(act_mem[idx_r], i_avs_writedata, i_avs_byteenable);
        end
        `ACL_OFF_PROCESS: begin
          proc_mem[idx_r] <= 4'(be_merge({28'h0, proc_mem[idx_r]}, i_avs_writedata,
                                         i_avs_byteenable));
        end
        default: ;
      endcase
    end
  end

  // Read data, registered on the same edge at which waitrequest drops
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_avs_readdata <= '0;
    end else if (rd_go) begin
      case (i_avs_address)
        `ACL_OFF_CTRL: o_avs_readdata <= {31'h0, acl_en_r};
        `ACL_OFF_INDEX: o_avs_readdata <= {28'h0, idx_r};
        `ACL_OFF_MATCH: o_avs_readdata <= {28'h0, match_mem[idx_r]};
        `ACL_OFF_ACTION: o_avs_readdata <= act_mem[idx_r];
        `ACL_OFF_PROCESS: o_avs_readdata <= {28'h0, proc_mem[idx_r]};
        `ACL_OFF_PORT_STAT: o_avs_readdata <= {31'h0, port_stat_r};
        `ACL_OFF_PORT_MASK: o_avs_readdata <= {31'h0, port_mask_r};
        `ACL_OFF_GLB_STAT: o_avs_readdata <= {31'h0, port_stat_r & port_mask_r};
        `ACL_OFF_GLB_MASK: o_avs_readdata <= {31'h0, glb_mask_r};
        default: o_avs_readdata <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Time bases: microsecond tick from the core clock, millisecond from that
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      us_cnt_r <= '0;
      us_tick_r <= 1'b0;
    end else if (us_cnt_r == 16'(US_CYCLES - 1)) begin
      us_cnt_r <= '0;
      us_tick_r <= 1'b1;
    end else begin
      us_cnt_r <= us_cnt_r + 16'h0001;
      us_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ms_cnt_r <= '0;
      ms_tick_r <= 1'b0;
    end else begin
      ms_tick_r <= 1'b0;
      if (us_tick_r) begin
        if (ms_cnt_r == 16'(US_PER_MS - 1)) begin
          ms_cnt_r <= '0;
          ms_tick_r <= 1'b1;
        end else begin
          ms_cnt_r <= ms_cnt_r + 16'h0001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count engines, one per entry; match and action fields work together here
  for (genvar g = 0; g < `ACL_NUM_ENTRIES; g++) begin : g_eng
    acl_cnt_engine u_eng (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_enable(acl_en_r & is_count(match_mem[g])),
      .i_alg(act_mem[g][`ACL_A_ALG]),
      .i_tb_sel(act_mem[g][`ACL_A_TBS]),
      .i_count(act_mem[g][`ACL_CNT_W-1:0]),
      .i_us_tick(us_tick_r),
      .i_ms_tick(ms_tick_r),
      .i_pkt(i_frm.valid & i_frm.mac_hit[g] & i_frm.type_hit[g]),
      .o_expire(expire[g])
    );
  end

  // Port status: sticky, write one to clear, a new event wins over the clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      port_stat_r <= 1'b0;
    end else if (any_expire) begin
      port_stat_r <= 1'b1;
    end else if (wr_go && i_avs_address == `ACL_OFF_PORT_STAT &&
                 i_avs_byteenable[0] && i_avs_writedata[0]) begin
      port_stat_r <= 1'b0;
    end
  end

  // Interrupt request through port and global masks
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= port_stat_r & port_mask_r & glb_mask_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Action selection: lowest-index filtering hit, count entries excluded
  logic sel_found;
  logic [`ACL_IDX_W-1:0] sel_idx;
  acl_pkg::acl_action_t sel_act;

  always_comb begin
    sel_found = 1'b0;
    sel_idx = '0;
    for (int e = 0; e < `ACL_NUM_ENTRIES; e++) begin
      if (!sel_found && i_frm.rule_hit[e] &&
          match_mem[e][`ACL_M_MODE_LO +: 2] != `ACL_MODE_OFF &&
          !is_count(match_mem[e])) begin
        sel_found = 1'b1;
        sel_idx = `ACL_IDX_W'(e);
      end
    end
    sel_act = decode_action(act_mem[proc_mem[sel_idx]]);
  end

  // Result stage, one cycle after the frame
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_res <= '0;
    end else begin
      o_res.valid <= i_frm.valid;
      if (i_frm.valid && acl_en_r && sel_found) begin
        o_res.prio <= apply_prio(sel_act.priority_mode, sel_act.priority_value,
                                 i_frm.qos_prio);
        o_res.pcp <= sel_act.remark_enable ? sel_act.remark_priority : i_frm.pcp;
        o_res.remarked <= sel_act.remark_enable;
        o_res.fwd_map <= apply_map(sel_act.map_mode, sel_act.fwd_map, i_frm.lut_map);
      end else begin
        o_res.prio <= i_frm.qos_prio;
        o_res.pcp <= i_frm.pcp;
        o_res.remarked <= 1'b0;
        o_res.fwd_map <= i_frm.lut_map;
      end
    end
  end

endmodule // acl_action_count_logic

/* File: verif/acl_lookup_model.sv */
// Lookup and QoS pipeline model that presents frames to the ACL stage
`timescale 1ns/1ps
module acl_lookup_model (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire acl_pkg::acl_frame_t i_req,
  output acl_pkg::acl_frame_t o_frm
);
  // One cycle per frame; between frames the hit and data fields toggle, never trusted
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_frm <= '0;
    end else if (i_req.valid) begin
      o_frm <= i_req;
    end else begin
      o_frm <= {1'b0, ~o_frm[$bits(o_frm)-2:0]};
    end
  end
endmodule // acl_lookup_model

/* File: verif/acl_action_count_logic_monitor.sv */
// Port-level checks of the ACL action stage
`timescale 1ns/1ps
`include "acl_consts.svh"
module acl_action_count_logic_monitor #(
  parameter int US_CYCLES = 50,
  parameter int US_PER_MS = 1000
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [`ACL_ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  input wire acl_pkg::acl_frame_t i_frm,
  input wire acl_pkg::acl_result_t o_res,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  logic wr_off;
  // Write taken that clears bit 0 of a register
  assign wr_off = i_avs_write && !o_avs_waitrequest && i_avs_byteenable[0] && !i_avs_writedata[0];
  ////////////////////////////////////////
  a_wait_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=>
    !o_avs_waitrequest) else $error("request not answered after one cycle");
  a_wait_single: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_read_hold: assert property ($changed(o_avs_readdata) |-> i_avs_read && !o_avs_waitrequest)
    else $error("read data changed outside a read");
  a_unmapped_zero: assert property (i_avs_read && !o_avs_waitrequest &&
    i_avs_address > `ACL_OFF_GLB_MASK |-> o_avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_result_timing: assert property (i_frm.valid |=> o_res.valid)
    else $error("result not one cycle after frame");
  a_pass_through: assert property (i_frm.valid && i_frm.rule_hit == 16'h0 |=>
    o_res.prio == $past(i_frm.qos_prio) && o_res.fwd_map == $past(i_frm.lut_map)
    && !o_res.remarked) else $error("frame without hit altered");
  a_pcp_kept: assert property (o_res.valid && !o_res.remarked |->
    o_res.pcp == $past(i_frm.pcp)) else $error("tag priority changed without remark");
  a_glb_mask_off: assert property (wr_off && i_avs_address == `ACL_OFF_GLB_MASK |->
    ##2 !o_irq [*2]) else $error("interrupt with global mask off");
  a_port_mask_off: assert property (wr_off && i_avs_address == `ACL_OFF_PORT_MASK |->
    ##2 !o_irq) else $error("interrupt with port mask off");
  c_remark: cover property (o_res.valid && o_res.remarked);
  c_irq: cover property ($rose(o_irq));
  c_unmapped: cover property (i_avs_read && !o_avs_waitrequest && i_avs_address > 6'h20);
endmodule // acl_action_count_logic_monitor
bind acl_action_count_logic acl_action_count_logic_monitor #(
  .US_CYCLES(US_CYCLES), .US_PER_MS(US_PER_MS)
) u_monitor (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .i_frm(i_frm), .o_res(o_res), .o_irq(o_irq));

/* File: verif/tb_acl_action_count_logic.sv */
// Self-checking bench of the ACL action stage
`timescale 1ns/1ps
`include "acl_consts.svh"
module tb_acl_action_count_logic;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [5:0] adr = 6'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] o_rd;
  logic [31:0] rdat;
  logic wt;
  logic irq;
  acl_pkg::acl_frame_t req = '0;
  acl_pkg::acl_frame_t frm;
  acl_pkg::acl_result_t res;
  acl_pkg::acl_result_t got;
  int failures = 0;
  int comparisons = 0;
  always #10 i_clk = ~i_clk;
  acl_action_count_logic #(.US_CYCLES(4), .US_PER_MS(3)) dut (.i_clk(i_clk),
    .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(o_rd),
    .o_avs_waitrequest(wt), .i_frm(frm), .o_res(res), .o_irq(irq));
  acl_lookup_model u_pipe (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_req(req), .o_frm(frm));
  ////////////////////////////////////////
  task automatic stop_test;
    if (failures == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Avalon cycle: hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge i_clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    rdat = o_rd;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wt !== 1'b0) begin
      failures++;
      stop_test();
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), rdat, e);
  endtask
  function automatic logic [31:0] act(input logic [1:0] pm, input logic [2:0] pr,
    input logic re, input logic [2:0] rp, input logic [1:0] mm, input logic tb, input logic al);
    return {9'h0, 7'h0f, 3'h0, al, tb, mm, rp, re, pr, pm};
  endfunction
  function automatic acl_pkg::acl_frame_t mk(input logic [15:0] h, input logic [15:0] m,
    input logic [15:0] t, input logic [2:0] q);
    return {1'b1, h, m, t, q, 3'h1, 7'h55};
  endfunction
  // One frame through the model, result captured when valid
  task automatic send(input acl_pkg::acl_frame_t f);
    int n;
    @(posedge i_clk);
    req <= f;
    @(posedge i_clk);
    req <= '0;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (res.valid !== 1'b1 && n < 6);
    got = res;
    if (got.valid !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    logic [5:0] offs [9] = '{`ACL_OFF_CTRL, `ACL_OFF_INDEX, `ACL_OFF_MATCH, `ACL_OFF_ACTION,
      `ACL_OFF_PROCESS, `ACL_OFF_PORT_STAT, `ACL_OFF_PORT_MASK, `ACL_OFF_GLB_STAT,
      `ACL_OFF_GLB_MASK};
    foreach (offs[k]) rdc(offs[k], `ACL_RST_WORD);
    check("irq", irq, 1'b0);
    bus(1'b1, 6'h3c, 32'hffff_ffff);
    rdc(6'h3c, 32'h0);
    bus(1'b1, `ACL_OFF_GLB_STAT, 32'h1);
    rdc(`ACL_OFF_GLB_STAT, 32'h0);
  endtask
  task automatic t_filter;
    logic [6:0] maps [4] = '{7'h55, 7'h5f, 7'h05, 7'h0f};
    logic [2:0] qs [2] = '{3'h3, 3'h7};
    logic [2:0] ep;
    bus(1'b1, `ACL_OFF_CTRL, 32'h1);
    bus(1'b1, `ACL_OFF_MATCH, 32'h6);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `ACL_OFF_ACTION, act(i[1:0], 3'h4, i[0], 3'h6, i[1:0], 1'b0, 1'b0));
      foreach (qs[j]) begin
        send(mk(16'h1, 16'h0, 16'h0, qs[j]));
        ep = (i == 3 || (i == 1 && 3'h4 > qs[j]) || (i == 2 && 3'h4 < qs[j])) ? 3'h4 : qs[j];
        check("prio", got.prio, ep);
        check("pcp", got.pcp, i[0] ? 3'h6 : 3'h1);
        check("remarked", got.remarked, i[0]);
        check("map", got.fwd_map, maps[i]);
      end
    end
    bus(1'b1, `ACL_OFF_CTRL, 32'h0);
    send(mk(16'h1, 16'h0, 16'h0, 3'h3));
    check("prio off", got.prio, 3'h3);
    rdc(`ACL_OFF_PORT_STAT, 32'h0);
  endtask
  // Frame counter of five, with MAC-only frames mixed in
  task automatic t_count;
    acl_pkg::acl_frame_t hit = mk(16'h0, 16'h2, 16'h2, 3'h0);
    bus(1'b1, `ACL_OFF_PORT_MASK, 32'h1);
    bus(1'b1, `ACL_OFF_GLB_MASK, 32'h1);
    bus(1'b1, `ACL_OFF_CTRL, 32'h1);
    bus(1'b1, `ACL_OFF_INDEX, 32'h1);
    bus(1'b1, `ACL_OFF_MATCH, 32'h1);
    bus(1'b1, `ACL_OFF_ACTION, act(2'h1, 3'h1, 1'b0, 3'h0, 2'h0, 1'b1, 1'b1));
    repeat (4) begin
      send(hit);
      send(mk(16'h0, 16'h2, 16'h0, 3'h0));
    end
    rdc(`ACL_OFF_PORT_STAT, 32'h0);
    send(hit);
    rdc(`ACL_OFF_PORT_STAT, 32'h1);
    rdc(`ACL_OFF_GLB_STAT, 32'h1);
    check("irq", irq, 1'b1);
    bus(1'b1, `ACL_OFF_GLB_MASK, 32'h0);
    rdc(`ACL_OFF_GLB_STAT, 32'h1);
    check("irq global mask", irq, 1'b0);
    bus(1'b1, `ACL_OFF_PORT_MASK, 32'h0);
    rdc(`ACL_OFF_GLB_STAT, 32'h0);
    bus(1'b1, `ACL_OFF_PORT_MASK, 32'h1);
    bus(1'b1, `ACL_OFF_GLB_MASK, 32'h1);
    bus(1'b1, `ACL_OFF_PORT_STAT, 32'h1);
    rdc(`ACL_OFF_PORT_STAT, 32'h0);
    check("irq cleared", irq, 1'b0);
    repeat (4) send(hit);
    rdc(`ACL_OFF_PORT_STAT, 32'h0);
  endtask
  // Gap timer of five units, refreshed once, then in milliseconds
  task automatic t_timer;
    acl_pkg::acl_frame_t hit = mk(16'h0, 16'h2, 16'h2, 3'h0);
    bus(1'b1, `ACL_OFF_MATCH, 32'h0);
    bus(1'b1, `ACL_OFF_ACTION, act(2'h1, 3'h1, 1'b0, 3'h0, 2'h0, 1'b0, 1'b0));
    bus(1'b1, `ACL_OFF_MATCH, 32'h1);
    bus(1'b1, `ACL_OFF_PORT_STAT, 32'h1);
    send(hit);
    repeat (10) @(posedge i_clk);
    send(hit);
    repeat (10) @(posedge i_clk);
    rdc(`ACL_OFF_PORT_STAT, 32'h0);
    repeat (10) @(posedge i_clk);
    rdc(`ACL_OFF_PORT_STAT, 32'h1);
    bus(1'b1, `ACL_OFF_ACTION, act(2'h1, 3'h1, 1'b0, 3'h0, 2'h0, 1'b1, 1'b0));
    bus(1'b1, `ACL_OFF_PORT_STAT, 32'h1);
    send(hit);
    repeat (30) @(posedge i_clk);
    rdc(`ACL_OFF_PORT_STAT, 32'h0);
    repeat (40) @(posedge i_clk);
    rdc(`ACL_OFF_PORT_STAT, 32'h1);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clk);
    i_arst_n <= 1'b1;
    t_reset();
    t_filter();
    t_count();
    t_timer();
    stop_test();
  end
endmodule // tb_acl_action_count_logic
